// ==== dv/scb_spi_ctrl_bench.sv ====
// self-checking bench of the spi control block
`include "scb_spi_defines.vh"

module scb_spi_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk = 1'b0, srst = 1'b1, lightStop = 1'b0, deepStop = 1'b0;
   logic [4:0]  avs_address = 5'h00;
   logic        avs_read = 1'b0, avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata;
   logic        avs_waitrequest, spiIrq, sclkOut, sclkOe, mosiOut, mosiOe;
   logic        misoOut, misoOe, ssOut, ssOe, peerMiso, extSelN = 1'b1;
   logic [7:0]  peerRx, rdv, dat;
   logic [7:0]  codes [5] = '{8'h11, 8'h00, 8'h70, 8'h26, 8'h17};
   int          err_total = 0, num_checks = 0, per, t0;

   initial forever #5 mclk = ~mclk;

   scb_spi_ctrl i_dut (.mclk(mclk), .srst(srst), .lightStop(lightStop), .deepStop(deepStop),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'h1), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .spiIrq(spiIrq), .sclkOut(sclkOut), .sclkOe(sclkOe),
      .sclkIn(sclkOe ? sclkOut : 1'b0), .mosiOut(mosiOut), .mosiOe(mosiOe),
      .mosiIn(mosiOe ? mosiOut : 1'b0), .misoOut(misoOut), .misoOe(misoOe),
      .misoIn(misoOe ? misoOut : peerMiso), .ssOut(ssOut), .ssOe(ssOe),
      .ssIn(ssOe ? ssOut : extSelN));
   scb_spi_peer i_peer (.sclk(sclkOut), .mosi(mosiOut), .selN(ssOut), .miso(peerMiso),
      .txByte(8'h5a), .rxByte(peerRx));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask
   task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= {24'h000000, d};
      avs_read <= !wr;
      avs_write <= wr;
      do begin
         @(posedge mclk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 100);
      rdv = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 100) chk(1, 0, "bus timeout");
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [4:0] a, input logic [7:0] exp, input string msg);
      bus(1'b0, a, 8'h00);
      chk(rdv, exp, msg);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic waitSs(input logic lv);
      int n;
      n = 0;
      while (ssOut !== lv && n < 20000) begin
         @(posedge mclk);
         n++;
      end
      if (n >= 20000) chk(1, 0, "select timeout");
   endtask
   task automatic end_sim;
      $display("checks %0d, errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      #400us;
      err_total++;
      end_sim;
   end

   initial begin
      cyc(20);
      srst <= 1'b0;
      rd(`SCB_ADDR_CONTROL_1, 8'h00, "control reset");
      rd(`SCB_ADDR_BAUD, 8'h00, "baud reset");
      rd(`SCB_ADDR_STATUS, 8'h20, "status reset");
      rd(5'h14, 8'h00, "unmapped read");
      wr(`SCB_ADDR_STATUS, 8'hff);
      rd(`SCB_ADDR_STATUS, 8'h20, "status write ignored");
      wr(`SCB_ADDR_CONTROL_1, 8'h70);
      cyc(3);
      chk(spiIrq, 1'b1, "tx empty irq");
      wr(`SCB_ADDR_CONTROL_1, 8'hd0);
      cyc(3);
      chk(spiIrq, 1'b0, "tx irq masked");
      for (int i = 0; i < 5; i++) begin
         dat = 8'h3c + 8'(i);
         wr(`SCB_ADDR_BAUD, codes[i]);
         bus(1'b0, `SCB_ADDR_STATUS, 8'h00);
         wr(`SCB_ADDR_DATA, dat);
         @(posedge sclkOut);
         t0 = $time;
         @(posedge sclkOut);
         per = ($time - t0) / 10;
         chk(per, (codes[i][6:4] + 1) * (2 << codes[i][2:0]), "sclk period");
         waitSs(1'b1);
         cyc(3);
         chk(spiIrq, 1'b1, "rx full irq");
         chk(peerRx, dat, "byte sent");
         rd(`SCB_ADDR_STATUS, 8'ha0, "rx full flags");
         if (i == 0) rd(`SCB_ADDR_DATA, 8'h5a, "byte received");
         else bus(1'b0, `SCB_ADDR_DATA, 8'h00);
         cyc(3);
         chk(spiIrq, 1'b0, "rx irq cleared");
      end
      wr(`SCB_ADDR_BAUD, 8'h00);
      bus(1'b0, `SCB_ADDR_STATUS, 8'h00);
      wr(`SCB_ADDR_DATA, 8'hc3);
      waitSs(1'b0);
      waitSs(1'b1);
      wr(`SCB_ADDR_BAUD, 8'h17);
      rd(`SCB_ADDR_STATUS, 8'ha0, "rx full before abort");
      wr(`SCB_ADDR_DATA, 8'hc3);
      waitSs(1'b0);
      cyc(50);
      wr(`SCB_ADDR_CONTROL_1, 8'h10);
      cyc(3);
      chk(ssOut, 1'b1, "abort releases select");
      rd(`SCB_ADDR_STATUS, 8'h20, "disable flags");
      rd(`SCB_ADDR_DATA, 8'h00, "buffers cleared");
      wr(`SCB_ADDR_CONTROL_2, 8'h10);
      wr(`SCB_ADDR_CONTROL_1, 8'hd0);
      extSelN <= 1'b0;
      cyc(6);
      chk(spiIrq, 1'b1, "mode fault irq");
      extSelN <= 1'b1;
      rd(`SCB_ADDR_STATUS, 8'h30, "mode fault flag");
      rd(`SCB_ADDR_CONTROL_1, 8'hc0, "master bit dropped");
      wr(`SCB_ADDR_CONTROL_1, 8'h00);
      wr(`SCB_ADDR_CONTROL_2, 8'h00);
      rd(`SCB_ADDR_STATUS, 8'h20, "mode fault cleared");
      wr(`SCB_ADDR_BAUD, 8'h35);
      wr(`SCB_ADDR_CONTROL_1, 8'h70);
      lightStop <= 1'b1;
      cyc(5);
      chk(spiIrq, 1'b0, "irq off in stop");
      chk(sclkOe | mosiOe | ssOe, 1'b0, "pins off in stop");
      lightStop <= 1'b0;
      cyc(3);
      chk(spiIrq, 1'b1, "irq back after stop");
      rd(`SCB_ADDR_CONTROL_1, 8'h70, "control kept");
      rd(`SCB_ADDR_BAUD, 8'h35, "baud kept");
      lightStop <= 1'b1;
      cyc(3);
      srst <= 1'b1;
      cyc(2);
      srst <= 1'b0;
      lightStop <= 1'b0;
      rd(`SCB_ADDR_CONTROL_1, 8'h00, "reset exit");
      wr(`SCB_ADDR_CONTROL_1, 8'h70);
      wr(`SCB_ADDR_BAUD, 8'h35);
      deepStop <= 1'b1;
      cyc(3);
      deepStop <= 1'b0;
      rd(`SCB_ADDR_CONTROL_1, 8'h00, "deep stop control");
      rd(`SCB_ADDR_BAUD, 8'h00, "deep stop baud");
      rd(`SCB_ADDR_STATUS, 8'h20, "deep stop status");
      chk(spiIrq, 1'b0, "deep stop irq");
      end_sim;
   end
endmodule // scb_spi_ctrl_bench

// ==== dv/scb_spi_ctrl_monitor.sv ====
// concurrent checks on the ports of the spi control block
`include "scb_spi_defines.vh"

module scb_spi_ctrl_monitor (
   // clock and reset
   input wire logic        mclk,
   input wire logic        srst,
   // power modes
   input wire logic        lightStop,
   input wire logic        deepStop,
   // register bus
   input wire logic [4:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   // interrupt and pins
   input wire logic        spiIrq,
   input wire logic        sclkOe,
   input wire logic        mosiOe,
   input wire logic        misoOe,
   input wire logic        ssOe,
   input wire logic        ssOut
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);

   // *****************
   // properties
   // *****************
   property p_stop_pins;
      lightStop |=> !(sclkOe || mosiOe || misoOe || ssOe);
   endproperty
   a_stop_pins: assert property (p_stop_pins) else $error("pins driven in stop");
   property p_stop_irq;
      lightStop |=> !spiIrq;
   endproperty
   a_stop_irq: assert property (p_stop_irq) else $error("irq in stop");
   property p_deep_reset;
      deepStop |=> avs_waitrequest && !spiIrq && ssOut && !(sclkOe || ssOe);
   endproperty
   a_deep_reset: assert property (p_deep_reset) else $error("deep stop not reset");
   property p_light_freeze;
      lightStop && !deepStop |=> $stable(avs_readdata) && $stable(avs_waitrequest);
   endproperty
   a_light_freeze: assert property (p_light_freeze) else $error("state moved");
   property p_one_wait;
      (avs_read || avs_write) && avs_waitrequest && !lightStop && !deepStop
         |=> !avs_waitrequest ##1 avs_waitrequest;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("wait state count");
   property p_rd_upper;
      !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000;
   endproperty
   a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
   property p_rd_hold;
      avs_waitrequest && !deepStop |=> $stable(avs_readdata) || !avs_waitrequest;
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   property p_status_zero;
      avs_read && avs_address == `SCB_ADDR_STATUS && avs_waitrequest && !lightStop
         && !deepStop |=> !avs_waitrequest && (avs_readdata[7:0] & 8'h4f) == 8'h00;
   endproperty
   a_status_zero: assert property (p_status_zero) else $error("status spare bit");
endmodule // scb_spi_ctrl_monitor

bind scb_spi_ctrl scb_spi_ctrl_monitor i_mon (.mclk(mclk), .srst(srst),
   .lightStop(lightStop), .deepStop(deepStop), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .spiIrq(spiIrq), .sclkOe(sclkOe),
   .mosiOe(mosiOe), .misoOe(misoOe), .ssOe(ssOe), .ssOut(ssOut));

// ==== dv/scb_spi_peer.sv ====
// behavioural serial peripheral on the far side of the link, mode 0, msb first
module scb_spi_peer (
   // link
   input  wire logic       sclk,
   input  wire logic       mosi,
   input  wire logic       selN,
   output logic            miso,
   // data
   input  wire logic [7:0] txByte,
   output logic [7:0]      rxByte
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] shift;
   initial begin
      miso = 1'b0;
      rxByte = 8'h00;
   end
   always @(negedge selN) begin
      shift = txByte;
      miso = shift[7];
   end
   // a released line shows the inverse of its last bit
   always @(posedge selN) miso = ~miso;
   always @(posedge sclk) if (!selN) rxByte = {rxByte[6:0], mosi};
   always @(negedge sclk) if (!selN) begin
      shift = {shift[6:0], 1'b0};
      miso = shift[7];
   end
endmodule // scb_spi_peer

// ==== verilog/scb_baud_div.v ====
// baud divider: half-period tick of the serial clock from the bus clock
`include "scb_spi_defines.vh"

module scb_baud_div (
   // clock and reset
   input  wire       mclk,
   input  wire       srst,
   // control
   input  wire       run,
   input  wire [2:0] prescaleSel,
   input  wire [2:0] rateSel,
   // tick out
   output reg        halfTick
);

   // ***************************************************************
   // divisor decode
   // ***************************************************************
   wire [3:0]  preDiv;
   wire [8:0]  rateDiv;
   wire [12:0] fullDiv;
   wire [11:0] halfDiv;
   reg  [11:0] count;

   assign preDiv  = {1'b0, prescaleSel} + 4'h1;                 // see RL11
   assign rateDiv = 9'h002 << rateSel;                          // see RL12
   // serial clock period is prescale times rate bus cycles
   assign fullDiv = preDiv * rateDiv;                           // see RL15
   assign halfDiv = fullDiv[12:1];

   // ***************************************************************
   // counter
   // ***************************************************************
   always @(posedge mclk) begin
      if (srst) begin
         count    <= 12'h000;
         halfTick <= 1'b0;
      end else if (!run) begin
         // light stop: hold count and tick so the serial clock resumes in phase
         count    <= count;
         halfTick <= halfTick;
      end else if (count >= halfDiv - 12'h001) begin
         count    <= 12'h000;
         halfTick <= 1'b1;
      end else begin
         count    <= count + 12'h001;
         halfTick <= 1'b0;
      end
   end

endmodule // scb_baud_div

// ==== verilog/scb_spi_ctrl.v ====
// spi control, status, baud selection and stop-mode handling with a small shift engine
//
// Operation
// RL1: every stop mode disables the interface regardless of prior configuration.
// RL2: deep and deepest stop power the interface down; wake-up gives reset state.
// RL3: light stop halts interface clocks; all registers keep their values.
// RL4: leaving light stop by reset puts the interface into reset state.
// RL5: leaving light stop by interrupt resumes exactly the held state.
// RL6: five 8-bit registers: control 1, control 2, baud, status, data.
// RL7: interrupt while control bit 7 set and receive-full or mode-fault flag set.
// RL8: clearing control bit 6 halts transfer, clears buffers, resets state machines.
// RL9: disabled interface clears receive-full and sets transmit-empty.
// RL10: interrupt while control bit 5 set and transmit-empty flag set.
// RL11: prescale code n gives prescaler divisor n plus one, 1 to 8.
// RL12: rate code n gives rate divisor two to the n plus one, 2 to 256.
// RL13: status has three read-only bits; bits 6,3,2,1,0 read zero.
// RL14: software writes to the status register change nothing.
// RL15: serial clock is bus clock divided by prescale times rate divisor.
// RL16: receive-full at status bit 7, transmit-empty bit 5, mode-fault bit 4.
//
// Chosen here: the Avalon-MM register port and the address map.
`include "scb_spi_defines.vh"

module scb_spi_ctrl (
   // clock and reset
   input  wire        mclk,
   input  wire        srst,
   // power modes
   input  wire        lightStop,
   input  wire        deepStop,
   // avalon-mm slave
   input  wire [4:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output reg  [31:0] avs_readdata,
   output reg         avs_waitrequest,
   // interrupt request
   output reg         spiIrq,
   // serial link
   output reg         sclkOut,
   output reg         sclkOe,
   input  wire        sclkIn,
   output reg         mosiOut,
   output reg         mosiOe,
   input  wire        mosiIn,
   output reg         misoOut,
   output reg         misoOe,
   input  wire        misoIn,
   output reg         ssOut,
   output reg         ssOe,
   input  wire        ssIn
);

   // ***************************************************************
   // declarations
   // ***************************************************************
   localparam ST_IDLE  = 2'b01;
   localparam ST_SHIFT = 2'b10;

   reg  [7:0] control1;
   reg  [7:0] control2;
   reg  [7:0] baud;
   reg  [7:0] txBuf;
   reg  [7:0] rxBuf;
   reg  [7:0] shiftReg;
   reg  [2:0] bitCnt;
   reg  [1:0] state;
   reg        rxFull;
   reg        txEmpty;
   reg        modeFault;
   reg        rxArm;
   reg        txArm;
   reg        faultArm;
   reg        sampleBit;
   reg        sclkInt;
   reg  [1:0] sclkSync;
   reg  [1:0] mosiSync;
   reg  [1:0] misoSync;
   reg  [1:0] ssSync;
   reg        sclkPrev;
   reg        ssPrev;
   reg  [7:0] next_readData;

   wire       rst;
   wire       run;
   wire       enable;
   wire       isMaster;
   wire       halfTick;
   wire       accRead;
   wire       accWrite;
   wire       wrLane;
   wire       slvRise;
   wire       slvFall;
   wire       slvSelect;
   wire [7:0] statusVal;
   wire [7:0] shifted;

   // deep stops act as reset, so wake-up finds the reset state
   assign rst       = srst | deepStop;                              // see RL2, RL4
   // light stop freezes every flip-flop in place except those of the registered outputs
   assign run       = ~lightStop;                                   // see RL3, RL5
   assign enable    = control1[`SCB_C1_SYSTEM_ENABLE];
   assign isMaster  = control1[`SCB_C1_MASTER];
   assign accRead   = avs_read & ~avs_waitrequest;
   assign accWrite  = avs_write & ~avs_waitrequest;
   assign wrLane    = accWrite & avs_byteenable[0];
   assign slvRise   = sclkSync[1] & ~sclkPrev;
   assign slvFall   = ~sclkSync[1] & sclkPrev;
   assign slvSelect = ~ssSync[1];
   assign statusVal = {rxFull, 1'b0, txEmpty, modeFault, 4'h0};     // see RL13, RL16

   // ***************************************************************
   // synchronisers for link inputs
   // ***************************************************************
   always @(posedge mclk) begin
      if (rst) begin
         sclkSync <= 2'b00;
         mosiSync <= 2'b00;
         misoSync <= 2'b00;
         ssSync   <= 2'b11;
         sclkPrev <= 1'b0;
         ssPrev   <= 1'b1;
      end else if (run) begin
         sclkSync <= {sclkSync[0], sclkIn};
         mosiSync <= {mosiSync[0], mosiIn};
         misoSync <= {misoSync[0], misoIn};
         ssSync   <= {ssSync[0], ssIn};
         sclkPrev <= sclkSync[1];
         ssPrev   <= ssSync[1];
      end
   end

   // ***************************************************************
   // baud divider
   // ***************************************************************
   scb_baud_div u_baud (
      .mclk        (mclk),
      .srst        (rst | ~(enable & isMaster & (state == ST_SHIFT))),  // see RL1
      .run         (run),                                              // see RL3, RL5
      .prescaleSel (baud[6:4]),
      .rateSel     (baud[2:0]),
      .halfTick    (halfTick)
   );

   // ***************************************************************
   // bus slave: one wait state, answer at the second edge
   // ***************************************************************
   always @* begin
      next_readData = 8'h00;
      case (avs_address)
         `SCB_ADDR_CONTROL_1: next_readData = control1;
         `SCB_ADDR_CONTROL_2: next_readData = control2;
         `SCB_ADDR_BAUD:      next_readData = baud;
         `SCB_ADDR_STATUS:    next_readData = statusVal;       // see RL13
         `SCB_ADDR_DATA:      next_readData = rxBuf;
         default:             next_readData = 8'h00;
      endcase
   end

   always @(posedge mclk) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h00000000;
      end else if (run) begin
         if ((avs_read | avs_write) & avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
            avs_readdata    <= {24'h000000, next_readData};
         end else begin
            avs_waitrequest <= 1'b1;
         end
      end
   end

   // ***************************************************************
   // software registers
   // ***************************************************************
   always @(posedge mclk) begin
      if (rst) begin
         control1 <= `SCB_RST_CONTROL_1;
         control2 <= `SCB_RST_CONTROL_2;
         baud     <= `SCB_RST_BAUD;
      end else if (run) begin
         // status address has no write path at all
         if (wrLane && avs_address == `SCB_ADDR_CONTROL_1) begin   // see RL6, RL14
            control1 <= avs_writedata[7:0] & `SCB_MASK_CONTROL_1;
         end else if (modeFault && isMaster) begin
            control1[`SCB_C1_MASTER] <= 1'b0;
         end
         if (wrLane && avs_address == `SCB_ADDR_CONTROL_2) begin
            control2 <= avs_writedata[7:0] & `SCB_MASK_CONTROL_2;
         end
         if (wrLane && avs_address == `SCB_ADDR_BAUD) begin
            baud <= avs_writedata[7:0] & `SCB_MASK_BAUD;
         end
      end
   end

   // ***************************************************************
   // flags, buffers and shift engine
   // ***************************************************************
   assign shifted = {shiftReg[6:0], sampleBit};

   always @(posedge mclk) begin
      if (rst) begin
         state     <= ST_IDLE;
         shiftReg  <= `SCB_RST_DATA;
         txBuf     <= `SCB_RST_DATA;
         rxBuf     <= `SCB_RST_DATA;
         bitCnt    <= 3'h0;
         sclkInt   <= 1'b0;
         sampleBit <= 1'b0;
         rxFull    <= 1'b0;
         txEmpty   <= 1'b1;
         modeFault <= 1'b0;
         rxArm     <= 1'b0;
         txArm     <= 1'b0;
         faultArm  <= 1'b0;
      end else if (run) begin
         if (accRead && avs_address == `SCB_ADDR_STATUS) begin
            rxArm    <= rxFull;
            txArm    <= txEmpty;
            faultArm <= modeFault;
         end
         if (!enable) begin
            // disabled: halt, empty the buffers, restart the engine
            state    <= ST_IDLE;                                   // see RL8
            shiftReg <= `SCB_RST_DATA;
            txBuf    <= `SCB_RST_DATA;
            rxBuf    <= `SCB_RST_DATA;
            bitCnt   <= 3'h0;
            sclkInt  <= 1'b0;
            rxFull   <= 1'b0;                                      // see RL9
            txEmpty  <= 1'b1;                                      // see RL9
            rxArm    <= 1'b0;
            txArm    <= 1'b0;
         end else begin
            if (wrLane && avs_address == `SCB_ADDR_DATA && txEmpty && txArm) begin
               txBuf   <= avs_writedata[7:0];
               txEmpty <= 1'b0;
               txArm   <= 1'b0;
            end
            // set of receive-full wins over a clear in the same cycle
            if (accRead && avs_address == `SCB_ADDR_DATA && rxArm) begin
               rxFull <= 1'b0;
               rxArm  <= 1'b0;
            end
            case (state)
               ST_IDLE: begin
                  sclkInt <= 1'b0;
                  bitCnt  <= 3'h0;
                  if (isMaster && !txEmpty && !modeFault) begin
                     shiftReg <= txBuf;
                     txEmpty  <= 1'b1;
                     state    <= ST_SHIFT;
                  end else if (!isMaster && slvSelect && ssPrev) begin
                     shiftReg <= txBuf;
                     txEmpty  <= 1'b1;
                     state    <= ST_SHIFT;
                  end
               end
               ST_SHIFT: begin
                  if (isMaster ? halfTick && sclkInt : slvFall) begin
                     shiftReg <= shifted;
                     bitCnt   <= bitCnt + 3'h1;
                     sclkInt  <= 1'b0;
                     if (bitCnt == `SCB_LAST_BIT) begin
                        rxBuf  <= shifted;
                        rxFull <= 1'b1;
                        state  <= ST_IDLE;
                     end
                  end else if (isMaster ? halfTick : slvRise) begin
                     // sample on the rising edge in both roles, shift on the falling one
                     sclkInt   <= isMaster;
                     sampleBit <= isMaster ? misoSync[1] : mosiSync[1];
                  end
                  if ((!isMaster && !slvSelect) || (isMaster && modeFault)) begin
                     state <= ST_IDLE;
                  end
               end
               default: state <= ST_IDLE;
            endcase
         end
         // mode fault: another master pulls select low; set wins over clear
         if (isMaster && control2[`SCB_C2_MODE_FAULT_EN] && slvSelect && enable) begin
            modeFault <= 1'b1;
         end else if (wrLane && avs_address == `SCB_ADDR_CONTROL_1 && faultArm) begin
            modeFault <= 1'b0;
            faultArm  <= 1'b0;
         end
      end
   end

   // ***************************************************************
   // registered outputs
   // ***************************************************************
   always @(posedge mclk) begin
      if (rst) begin
         spiIrq  <= 1'b0;
         sclkOut <= 1'b0;
         sclkOe  <= 1'b0;
         mosiOut <= 1'b0;
         mosiOe  <= 1'b0;
         misoOut <= 1'b0;
         misoOe  <= 1'b0;
         ssOut   <= 1'b1;
         ssOe    <= 1'b0;
      end else begin
         // pins released in any stop, registers untouched in light stop
         spiIrq  <= run & ((control1[`SCB_C1_RX_FAULT_IRQ_EN] & (rxFull | modeFault))  // see RL7
                    | (control1[`SCB_C1_TX_EMPTY_IRQ_EN] & txEmpty));                  // see RL10
         sclkOut <= sclkInt;
         mosiOut <= shiftReg[7];
         misoOut <= shiftReg[7];
         ssOut   <= ~(state == ST_SHIFT);
         sclkOe  <= run & enable & isMaster;                       // see RL1
         mosiOe  <= run & enable & isMaster;
         ssOe    <= run & enable & isMaster & ~control2[`SCB_C2_MODE_FAULT_EN];
         misoOe  <= run & enable & ~isMaster & slvSelect;
      end
   end

endmodule // scb_spi_ctrl

// ==== verilog/scb_spi_defines.vh ====
// register offsets, field positions, reset values and sizes of the spi control block
`ifndef SCB_SPI_DEFINES_VH
`define SCB_SPI_DEFINES_VH

// ***************************************************************
// register byte addresses
// ***************************************************************
`define SCB_ADDR_CONTROL_1   5'h00
`define SCB_ADDR_CONTROL_2   5'h04
`define SCB_ADDR_BAUD        5'h08
`define SCB_ADDR_STATUS      5'h0c
`define SCB_ADDR_DATA        5'h10

// ***************************************************************
// field positions
// ***************************************************************
`define SCB_C1_RX_FAULT_IRQ_EN 7
`define SCB_C1_SYSTEM_ENABLE   6
`define SCB_C1_TX_EMPTY_IRQ_EN 5
`define SCB_C1_MASTER          4
`define SCB_C2_MODE_FAULT_EN   4
`define SCB_BAUD_PRESCALE_LSB  4
`define SCB_BAUD_RATE_LSB      0
`define SCB_ST_RX_FULL         7
`define SCB_ST_TX_EMPTY        5
`define SCB_ST_MODE_FAULT      4

// ***************************************************************
// reset values and masks
// ***************************************************************
`define SCB_RST_CONTROL_1    8'h00
`define SCB_RST_CONTROL_2    8'h00
`define SCB_RST_BAUD         8'h00
`define SCB_RST_DATA         8'h00
`define SCB_MASK_CONTROL_1   8'hf0
`define SCB_MASK_CONTROL_2   8'h10
`define SCB_MASK_BAUD        8'h77
`define SCB_LAST_BIT         3'h7

`endif
